// [core/lcd_dev.sv]
// lcd device end: setup parameters, scan timing, sleep entry and exit
// assumes host keeps its own programming limits; pixel bytes from pix_byte_i
`timescale 1ns/100ps
`include "lcd_consts.svh"
module lcd_dev (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  lcd_if.dev               bus,
  input  wire logic [7:0]  pix_byte_i,
  output logic      [7:0]  col_byte_o,
  output logic             line_start_o,
  output logic             frame_start_o,
  output logic             row_driver_disable_n_o,
  output logic             osc_run_o,
  output logic      [15:0] mem_addr_o,
  output logic             dual_panel_o,
  output logic             display_on_cmd_o,
  output logic      [3:0]  char_height_param_o,
  output logic      [7:0]  visible_span_o,
  output logic      [7:0]  total_line_length_o,
  output logic      [7:0]  frame_lines_o,
  output logic      [15:0] virtual_width_span_o
);
  import lcd_pkg::*;

  lcd_dstate_e state;
  logic [3:0]  pidx;
  logic [3:0]  char_row;
  logic [15:0] line_base;
  logic [7:0]  col;
  logic        line_end;
  logic        frame_end;
  logic        cmd_wr;
  logic        dat_wr;
  logic        setup_cmd;
  logic        sleep_cmd;
  logic        dispon_cmd;
  logic        visible;
  logic        blank;

  // while asleep only the setup command is heard
  assign cmd_wr     = bus.wr && bus.a0;
  assign dat_wr     = bus.wr && !bus.a0;
  assign setup_cmd  = cmd_wr && (bus.wdata == `LCD_CMD_SETUP);
  assign sleep_cmd  = cmd_wr && (bus.wdata == `LCD_CMD_SLEEP) && (state == LD_AWAKE);
  assign dispon_cmd = cmd_wr && (bus.wdata == `LCD_CMD_DISPLAY_ON_CMD) && (state == LD_AWAKE);
  assign visible    = (col <= visible_span_o); // R04
  assign blank      = !display_on_cmd_o || (state != LD_AWAKE); // R12

  lcd_scan_timer u_timer (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .run_i       (state != LD_ASLEEP), // R11
    .restart_i   (setup_cmd), // R17
    .tcr_i       (total_line_length_o),
    .lf_i        (frame_lines_o),
    .col_o       (col),
    .line_o      (),
    .line_end_o  (line_end),
    .frame_end_o (frame_end)
  );

  // sleep sequence; setup wins over any step of it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= LD_AWAKE;
    end else if (setup_cmd) begin
      state <= LD_AWAKE; // R15 R17
    end else begin
      case (state)
        LD_AWAKE: begin
          if (sleep_cmd) begin
            state <= LD_DRAIN;
          end
        end
        LD_DRAIN: begin
          if (frame_end) begin
            state <= LD_BLANK;
          end
        end
        LD_BLANK: begin
          if (frame_end) begin
            state <= LD_ASLEEP; // R11 R13
          end
        end
        default: begin
          state <= LD_ASLEEP;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      row_driver_disable_n_o <= 1'b1;
      osc_run_o              <= 1'b1;
    end else if (setup_cmd) begin
      row_driver_disable_n_o <= 1'b1; // R15
      osc_run_o              <= 1'b1;
    end else if ((state == LD_BLANK) && frame_end) begin
      row_driver_disable_n_o <= 1'b0; // R12 R13
      osc_run_o              <= 1'b0; // R11
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      display_on_cmd_o <= 1'b0;
    end else if (setup_cmd) begin
      display_on_cmd_o <= 1'b0; // R17
    end else if (dispon_cmd) begin
      display_on_cmd_o <= 1'b1;
    end
  end

  // parameter index: 1 after setup, stops past the last parameter
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pidx <= 4'h0;
    end else if (setup_cmd) begin
      pidx <= 4'h1; // R19
    end else if (cmd_wr) begin
      pidx <= 4'h0;
    end else if (dat_wr && (pidx != 4'h0) && (pidx != `LCD_DONE_PARAM)) begin
      pidx <= pidx + 4'h1; // R19
    end
  end

  // parameters are never touched by sleep, only by setup bytes
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dual_panel_o         <= 1'b0;
      char_height_param_o  <= `LCD_RST_FY;
      visible_span_o       <= `LCD_RST_CR;
      total_line_length_o  <= `LCD_RST_TCR;
      frame_lines_o        <= `LCD_RST_LF;
      virtual_width_span_o <= `LCD_RST_AP;
    end else if (dat_wr) begin // R14
      case (pidx)
        4'h1: dual_panel_o <= bus.wdata[`LCD_WS_BIT]; // R18 R19
        4'h3: char_height_param_o <= bus.wdata[3:0]; // R01
        4'h4: begin
          if (bus.wdata > `LCD_CR_MAX) begin
            visible_span_o <= `LCD_CR_MAX; // R03
          end else begin
            visible_span_o <= bus.wdata; // R03
          end
        end
        4'h5: total_line_length_o <= bus.wdata; // R06
        4'h6: frame_lines_o <= bus.wdata; // R08
        4'h7: virtual_width_span_o[7:0] <= bus.wdata; // R10
        `LCD_LAST_PARAM: virtual_width_span_o[15:8] <= bus.wdata; // R10
        default: begin
        end
      endcase
    end
  end

  // line base steps by the virtual width once per character row
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      char_row  <= 4'h0;
      line_base <= 16'h0000;
    end else if (setup_cmd || frame_end) begin
      char_row  <= 4'h0;
      line_base <= 16'h0000;
    end else if (line_end) begin
      if (char_row >= char_height_param_o) begin
        char_row  <= 4'h0; // R01
        line_base <= line_base + virtual_width_span_o; // R10
      end else begin
        char_row <= char_row + 4'h1; // R01
      end
    end
  end

  // memory address only moves while the clock runs, so sleep freezes it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mem_addr_o <= 16'h0000;
    end else if ((state != LD_ASLEEP) && visible) begin
      mem_addr_o <= line_base + {8'h00, col}; // R14
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      col_byte_o    <= 8'h00;
      line_start_o  <= 1'b0;
      frame_start_o <= 1'b0;
    end else begin
      col_byte_o    <= (blank || !visible) ? 8'h00 : pix_byte_i; // R04 R12
      line_start_o  <= line_end || setup_cmd;
      frame_start_o <= frame_end || setup_cmd;
    end
  end

  // status answer the cycle after rd; lines stay released while asleep
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus.rdata      <= 8'h00;
      bus.rdata_oe_n <= 1'b1;
    end else if (bus.rd && (state != LD_ASLEEP)) begin
      bus.rdata      <= {5'h00, dual_panel_o, display_on_cmd_o, state != LD_AWAKE};
      bus.rdata_oe_n <= 1'b0;
    end else begin
      bus.rdata      <= 8'h00;
      bus.rdata_oe_n <= 1'b1; // R16
    end
  end
endmodule : lcd_dev

// [core/lcd_consts.svh]
// constants for the lcd frame timing and sleep control ends
// assumes one 40 MHz clock shared by host end and device end
// How it works
// R01: character height is parameter plus one
// R02: host forces height zero in graphics
// R03: visible line span is bytes minus one
// R04: bytes past visible span go blank
// R05: host bounds span and blank surplus
// R06: scan line lasts total length plus one
// R07: host keeps total length at least span plus four
// R08: frame holds lines parameter plus one
// R09: host makes lines parameter odd when dual
// R10: virtual width built low byte then high
// R11: sleep waits a blank frame, then halts
// R12: sleep blanks columns, drops row drivers
// R13: row disable falls one to two frames later
// R14: sleep keeps parameters and memory outputs
// R15: setup with first byte only wakes device
// R16: bus released while asleep
// R17: setup command restarts timing, display off, wakes
// R18: panel select bit picks single or dual
// R19: setup bytes fill parameters in fixed order
`ifndef LCD_CONSTS_SVH
`define LCD_CONSTS_SVH
`define LCD_CMD_SETUP      8'h01
`define LCD_CMD_SLEEP      8'h02
`define LCD_CMD_DISPLAY_ON_CMD    8'h03
`define LCD_WS_BIT         3
`define LCD_CR_MAX         8'hef
`define LCD_LAST_PARAM     4'h8
`define LCD_DONE_PARAM     4'h9
`define LCD_TCR_MARGIN     9'h004
`define LCD_SURPLUS_BYTES  16'h0008
`define LCD_RST_FY         4'h0
`define LCD_RST_CR         8'h00
`define LCD_RST_TCR        8'h04
`define LCD_RST_LF         8'h00
`define LCD_RST_AP         16'h0001
`define LCD_HREG_CMD       3'h0
`define LCD_HREG_FMT       3'h1
`define LCD_HREG_CR        3'h2
`define LCD_HREG_TCR       3'h3
`define LCD_HREG_LF        3'h4
`define LCD_HREG_APL       3'h5
`define LCD_HREG_APH       3'h6
`define LCD_HREG_STAT      3'h7
`define LCD_FMT_GFX_BIT    4
`define LCD_FMT_DUAL_BIT   5
`endif

// [core/lcd_pkg.sv]
// types shared by the host end and the device end
// assumes lcd_consts.svh for all numbers
package lcd_pkg;
  typedef enum logic [1:0] {
    LD_AWAKE  = 2'b00,
    LD_DRAIN  = 2'b01,
    LD_BLANK  = 2'b10,
    LD_ASLEEP = 2'b11
  } lcd_dstate_e;
  typedef enum logic [2:0] {
    LK_SETUP  = 3'b000,
    LK_WAKE   = 3'b001,
    LK_SLEEP  = 3'b010,
    LK_DISPON = 3'b011,
    LK_READ   = 3'b100
  } lcd_kind_e;
  typedef enum logic [1:0] {
    LH_IDLE = 2'b00,
    LH_SEND = 2'b01,
    LH_RD   = 2'b10,
    LH_RDW  = 2'b11
  } lcd_hstate_e;
endpackage : lcd_pkg

// [core/lcd_if.sv]
// parallel command/parameter bus between host and lcd device
// read data lines carry an active-low output enable, no tristate here
`timescale 1ns/100ps
interface lcd_if;
  logic       wr;
  logic       a0;
  logic [7:0] wdata;
  logic       rd;
  logic [7:0] rdata;
  logic       rdata_oe_n;
  modport dev (input wr, a0, wdata, rd, output rdata, rdata_oe_n);
  modport host (output wr, a0, wdata, rd, input rdata, rdata_oe_n);
endinterface : lcd_if

// [core/lcd_scan_timer.sv]
// byte and line counters of the scan timing generator
// assumes run low freezes every count, restart has priority
`timescale 1ns/100ps
module lcd_scan_timer (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       run_i,
  input  wire logic       restart_i,
  input  wire logic [7:0] tcr_i,
  input  wire logic [7:0] lf_i,
  output logic      [7:0] col_o,
  output logic      [7:0] line_o,
  output logic            line_end_o,
  output logic            frame_end_o
);
  import lcd_pkg::*;

  assign line_end_o  = run_i && !restart_i && (col_o >= tcr_i); // R06
  assign frame_end_o = line_end_o && (line_o >= lf_i); // R08

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      col_o <= 8'h00;
    end else if (restart_i || line_end_o) begin
      col_o <= 8'h00; // R06
    end else if (run_i) begin
      col_o <= col_o + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      line_o <= 8'h00;
    end else if (restart_i || frame_end_o) begin
      line_o <= 8'h00; // R08
    end else if (line_end_o) begin
      line_o <= line_o + 8'h01;
    end
  end
endmodule : lcd_scan_timer

// [core/lcd_host.sv]
// host end: register port for software, byte sequencer onto the lcd bus
// assumes device answers a status read in the cycle after rd
`timescale 1ns/100ps
`include "lcd_consts.svh"
module lcd_host (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  lcd_if.host             bus,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o
);
  import lcd_pkg::*;

  lcd_hstate_e state;
  logic [3:0]  idx;
  logic [3:0]  last;
  logic [5:0]  fmt;
  logic [7:0]  cr;
  logic [7:0]  tcr;
  logic [7:0]  lf;
  logic [15:0] ap;
  logic [2:0]  dev_stat;
  logic        err;
  logic        go;
  logic        bad;
  logic [15:0] span;

  assign go   = wr_i && (addr_i == `LCD_HREG_CMD) && (state == LH_IDLE);
  assign span = {8'h00, cr} + 16'h0001;
  // refuse a full setup that breaks the programming limits
  assign bad  = (lcd_kind_e'(wdata_i[2:0]) == LK_SETUP) &&
                (({1'b0, tcr} < ({1'b0, cr} + `LCD_TCR_MARGIN)) || // R07
                 (fmt[`LCD_FMT_DUAL_BIT] && !lf[0]) || // R09
                 (ap < span) || ((ap - span) > `LCD_SURPLUS_BYTES)); // R05

  function automatic logic [7:0] seq_byte(input logic [3:0] i);
    case (i)
      4'h1: seq_byte = fmt[`LCD_FMT_DUAL_BIT] ? 8'h08 : 8'h00; // R18
      4'h3: seq_byte = fmt[`LCD_FMT_GFX_BIT] ? 8'h00 : {4'h0, fmt[3:0]}; // R02
      4'h4: seq_byte = cr;
      4'h5: seq_byte = tcr;
      4'h6: seq_byte = lf;
      4'h7: seq_byte = ap[7:0]; // R10
      4'h8: seq_byte = ap[15:8]; // R10
      default: seq_byte = 8'h00;
    endcase
  endfunction : seq_byte

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fmt <= 6'h00;
      cr  <= `LCD_RST_CR;
      tcr <= `LCD_RST_TCR;
      lf  <= `LCD_RST_LF;
      ap  <= `LCD_RST_AP;
    end else if (wr_i) begin
      if (addr_i == `LCD_HREG_FMT) begin
        fmt <= wdata_i[5:0];
      end else if (addr_i == `LCD_HREG_CR) begin
        cr <= wdata_i;
      end else if (addr_i == `LCD_HREG_TCR) begin
        tcr <= wdata_i;
      end else if (addr_i == `LCD_HREG_LF) begin
        lf <= wdata_i;
      end else if (addr_i == `LCD_HREG_APL) begin
        ap[7:0] <= wdata_i;
      end else if (addr_i == `LCD_HREG_APH) begin
        ap[15:8] <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      err <= 1'b0;
    end else if (go) begin
      err <= bad;
    end
  end

  // sequencer: command byte then parameters, one strobe per cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state     <= LH_IDLE;
      idx       <= 4'h0;
      last      <= 4'h0;
      bus.wr    <= 1'b0;
      bus.a0    <= 1'b0;
      bus.wdata <= 8'h00;
      bus.rd    <= 1'b0;
      dev_stat  <= 3'h0;
    end else begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      case (state)
        LH_IDLE: begin
          if (go && !bad) begin
            idx  <= 4'h1;
            if (lcd_kind_e'(wdata_i[2:0]) == LK_READ) begin
              bus.rd <= 1'b1;
              state  <= LH_RD;
            end else begin
              bus.wr    <= 1'b1;
              bus.a0    <= 1'b1;
              state     <= LH_SEND;
              bus.wdata <= (lcd_kind_e'(wdata_i[2:0]) == LK_SLEEP) ? `LCD_CMD_SLEEP :
                           (lcd_kind_e'(wdata_i[2:0]) == LK_DISPON) ? `LCD_CMD_DISPLAY_ON_CMD :
                           `LCD_CMD_SETUP;
              last      <= (lcd_kind_e'(wdata_i[2:0]) == LK_SETUP) ? `LCD_LAST_PARAM :
                           (lcd_kind_e'(wdata_i[2:0]) == LK_WAKE) ? 4'h1 : 4'h0; // R15
            end
          end
        end
        LH_SEND: begin
          if (idx > last) begin
            state <= LH_IDLE;
          end else begin
            bus.wr    <= 1'b1; // R19
            bus.a0    <= 1'b0;
            bus.wdata <= seq_byte(idx);
            idx       <= idx + 4'h1;
          end
        end
        LH_RD: begin
          state <= LH_RDW;
        end
        default: begin
          if (!bus.rdata_oe_n) begin
            dev_stat <= bus.rdata[2:0];
          end
          state <= LH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 8'h00;
    end else if (!rd_i) begin
      rdata_o <= 8'h00;
    end else if (addr_i == `LCD_HREG_FMT) begin
      rdata_o <= {2'b00, fmt};
    end else if (addr_i == `LCD_HREG_CR) begin
      rdata_o <= cr;
    end else if (addr_i == `LCD_HREG_TCR) begin
      rdata_o <= tcr;
    end else if (addr_i == `LCD_HREG_LF) begin
      rdata_o <= lf;
    end else if (addr_i == `LCD_HREG_APL) begin
      rdata_o <= ap[7:0];
    end else if (addr_i == `LCD_HREG_APH) begin
      rdata_o <= ap[15:8];
    end else if (addr_i == `LCD_HREG_STAT) begin
      rdata_o <= {state != LH_IDLE, err, 3'b000, dev_stat};
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule : lcd_host

// [sim/lcd_monitor.sv]
// checker on the lcd bus and the device outputs
// assumes one clock domain; tb_top wires every input by name
`timescale 1ns/100ps
`include "lcd_consts.svh"
module lcd_monitor (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        wr,
  input  wire logic        a0,
  input  wire logic [7:0]  wdata,
  input  wire logic        rd,
  input  wire logic        rdata_oe_n,
  input  wire logic [7:0]  col_byte_o,
  input  wire logic        line_start_o,
  input  wire logic        frame_start_o,
  input  wire logic        row_driver_disable_n_o,
  input  wire logic        osc_run_o,
  input  wire logic        display_on_cmd_o,
  input  wire logic [7:0]  total_line_length_o,
  input  wire logic [7:0]  frame_lines_o,
  input  wire logic [15:0] mem_addr_o
);
  logic        setup_cmd;
  logic [16:0] frame_len;
  logic [16:0] lgap;
  logic [16:0] fgap;
  logic [16:0] sgap;
  logic        armed;
  logic        slp_on;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  assign setup_cmd = wr && a0 && (wdata == `LCD_CMD_SETUP);
  assign frame_len = ({9'h000, frame_lines_o} + 17'h00001)
                   * ({9'h000, total_line_length_o} + 17'h00001);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lgap <= 17'h00000;
      fgap <= 17'h00000;
    end else begin
      lgap <= line_start_o ? 17'h00001 : lgap + 17'h00001;
      fgap <= frame_start_o ? 17'h00001 : fgap + 17'h00001;
    end
  end
  // periods only trusted once a frame start has passed with no byte written since
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      armed <= 1'b0;
    end else if (wr || !osc_run_o) begin
      armed <= 1'b0;
    end else if (frame_start_o) begin
      armed <= 1'b1;
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slp_on <= 1'b0;
      sgap   <= 17'h00000;
    end else if (setup_cmd || !row_driver_disable_n_o) begin
      slp_on <= 1'b0;
    end else if (wr && a0 && wdata == `LCD_CMD_SLEEP && !slp_on && osc_run_o) begin
      slp_on <= 1'b1;
      sgap   <= 17'h00000;
    end else begin
      sgap   <= sgap + 17'h00001;
    end
  end
  a_read_answer: assert property (rd && osc_run_o |=> !rdata_oe_n)
    else $error("status read not answered");
  a_oe_cause: assert property (!rdata_oe_n |-> $past(rd))
    else $error("read lines driven without read");
  a_sleep_hiz: assert property (!osc_run_o |-> rdata_oe_n)
    else $error("read lines driven while asleep");
  a_sleep_blank: assert property (!row_driver_disable_n_o |-> col_byte_o == 8'h00)
    else $error("column data not blank in sleep");
  a_setup_restart: assert property (setup_cmd |=> line_start_o && frame_start_o && !display_on_cmd_o)
    else $error("setup did not restart timing");
  a_setup_wake: assert property (setup_cmd |-> ##2 (osc_run_o && row_driver_disable_n_o))
    else $error("setup did not end sleep");
  a_halt_together: assert property ($fell(osc_run_o) |-> $fell(row_driver_disable_n_o))
    else $error("oscillator halted apart from row disable");
  a_row_window: assert property ($fell(row_driver_disable_n_o) |->
      slp_on && sgap >= frame_len && {1'b0, sgap} <= {frame_len, 1'b0})
    else $error("row disable outside one to two frames");
  a_line_period: assert property (line_start_o && armed |->
      lgap == {9'h000, total_line_length_o} + 17'h00001)
    else $error("line period wrong");
  a_frame_period: assert property (frame_start_o && armed |-> fgap == frame_len)
    else $error("frame period wrong");
  a_params_kept: assert property (!osc_run_o && !$past(osc_run_o) && !$past(setup_cmd) |->
      $stable(total_line_length_o) && $stable(frame_lines_o) && $stable(mem_addr_o))
    else $error("state changed during sleep");
endmodule : lcd_monitor

// [sim/tb_top.sv]
// self-checking bench: software port of the host end drives the device end
// assumes 40 MHz clock and the host register map of the design
`timescale 1ns/100ps
`include "lcd_consts.svh"
module tb_top;
  logic        clk_i;
  logic        reset_n_i;
  logic [2:0]  addr_i;
  logic [7:0]  wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [7:0]  rdata_o;
  logic [7:0]  pix_byte_i;
  logic [7:0]  col_byte_o;
  logic        line_start_o;
  logic        frame_start_o;
  logic        row_driver_disable_n_o;
  logic        osc_run_o;
  logic [15:0] mem_addr_o;
  logic        dual_panel_o;
  logic        display_on_cmd_o;
  logic [3:0]  char_height_param_o;
  logic [7:0]  visible_span_o;
  logic [7:0]  total_line_length_o;
  logic [7:0]  frame_lines_o;
  logic [15:0] virtual_width_span_o;
  int          errors;
  int          comparisons;
  int          n;
  logic [7:0]  rv;
  logic [15:0] ma;
  lcd_if bus_if ();
  lcd_host lcd_host_i (.clk_i, .reset_n_i, .bus(bus_if.host), .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o);
  lcd_dev lcd_dev_i (.clk_i, .reset_n_i, .bus(bus_if.dev), .pix_byte_i, .col_byte_o,
    .line_start_o, .frame_start_o, .row_driver_disable_n_o, .osc_run_o, .mem_addr_o,
    .dual_panel_o, .display_on_cmd_o, .char_height_param_o, .visible_span_o, .total_line_length_o,
    .frame_lines_o, .virtual_width_span_o);
  lcd_monitor lcd_monitor_i (.clk_i, .reset_n_i, .wr(bus_if.wr), .a0(bus_if.a0),
    .wdata(bus_if.wdata), .rd(bus_if.rd), .rdata_oe_n(bus_if.rdata_oe_n), .col_byte_o,
    .line_start_o, .frame_start_o, .row_driver_disable_n_o, .osc_run_o, .display_on_cmd_o,
    .total_line_length_o, .frame_lines_o, .mem_addr_o);
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic hang;
    errors++;
    complete_run();
  endtask : hang
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask : reg_rd
  // a command write is ignored while busy, so always wait it out
  task automatic send_cmd(input logic [7:0] c);
    logic [7:0] s;
    reg_wr(`LCD_HREG_CMD, c);
    for (int i = 0; i < 40; i++) begin
      reg_rd(`LCD_HREG_STAT, s);
      if (s[7] === 1'b0) return;
    end
    hang();
  endtask : send_cmd
  task automatic pulse_gap(input bit frm, output int g);
    bit got;
    got = 1'b0;
    g = 0;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk_i);
      #1;
      if (got) g++;
      if ((frm ? frame_start_o : line_start_o) === 1'b1) begin
        if (got) return;
        got = 1'b1;
      end
    end
    hang();
  endtask : pulse_gap
  initial begin
    reset_n_i = 1'b0;
    addr_i = 3'h0;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    pix_byte_i = 8'ha5;
    errors = 0;
    comparisons = 0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    #1;
    check("reset line", {8'h00, total_line_length_o}, 16'h0004);
    check("reset width", virtual_width_span_o, 16'h0001);
    check("reset row", {15'h0, row_driver_disable_n_o}, 16'h0001);
    // widest span, shortest legal line, dual panel, tallest character
    reg_wr(`LCD_HREG_FMT, 8'h2f);
    reg_wr(`LCD_HREG_CR, 8'hef);
    reg_wr(`LCD_HREG_TCR, 8'hf3);
    reg_wr(`LCD_HREG_LF, 8'h03);
    reg_wr(`LCD_HREG_APL, 8'hf4);
    reg_wr(`LCD_HREG_APH, 8'h00);
    send_cmd(8'h00);
    check("height", {12'h0, char_height_param_o}, 16'h000f);
    check("span", {8'h00, visible_span_o}, 16'h00ef);
    check("line", {8'h00, total_line_length_o}, 16'h00f3);
    check("lines", {8'h00, frame_lines_o}, 16'h0003);
    check("width", virtual_width_span_o, 16'h00f4);
    check("dual", {15'h0, dual_panel_o}, 16'h0001);
    pulse_gap(1'b0, n);
    check("line period", n[15:0], 16'd244);
    pulse_gap(1'b1, n);
    check("frame period", n[15:0], 16'd976);
    send_cmd(8'h03);
    n = 0;
    for (int i = 0; i < 244; i++) begin
      @(posedge clk_i);
      #1;
      if (col_byte_o !== 8'h00) n++;
    end
    check("shown bytes", n[15:0], 16'd240);
    send_cmd(8'h04);
    reg_rd(`LCD_HREG_STAT, rv);
    check("status", {8'h00, rv}, 16'h0006);
    send_cmd(8'h02);
    n = 0;
    while (row_driver_disable_n_o !== 1'b0 && n < 3000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 3000) hang();
    check("sleep delay", {15'h0, n >= 960 && n <= 1960}, 16'h0001);
    check("osc", {15'h0, osc_run_o}, 16'h0000);
    check("blank", {8'h00, col_byte_o}, 16'h0000);
    ma = mem_addr_o;
    send_cmd(8'h04);
    check("mem addr", mem_addr_o, ma);
    check("kept", {8'h00, total_line_length_o}, 16'h00f3);
    send_cmd(8'h01);
    check("awake row", {15'h0, row_driver_disable_n_o}, 16'h0001);
    check("awake osc", {15'h0, osc_run_o}, 16'h0001);
    check("still off", {15'h0, display_on_cmd_o}, 16'h0000);
    check("span kept", {8'h00, visible_span_o}, 16'h00ef);
    send_cmd(8'h03);
    check("display_on_cmd", {15'h0, display_on_cmd_o}, 16'h0001);
    // graphics mode forces height zero; single panel
    reg_wr(`LCD_HREG_FMT, 8'h1a);
    reg_wr(`LCD_HREG_CR, 8'h03);
    reg_wr(`LCD_HREG_TCR, 8'h07);
    reg_wr(`LCD_HREG_LF, 8'h04);
    reg_wr(`LCD_HREG_APL, 8'h06);
    send_cmd(8'h00);
    check("gfx height", {12'h0, char_height_param_o}, 16'h0000);
    check("single", {15'h0, dual_panel_o}, 16'h0000);
    check("off again", {15'h0, display_on_cmd_o}, 16'h0000);
    check("lines2", {8'h00, frame_lines_o}, 16'h0004);
    pulse_gap(1'b0, n);
    check("line period2", n[15:0], 16'd8);
    // too short a line is refused by the host
    reg_wr(`LCD_HREG_TCR, 8'h06);
    send_cmd(8'h00);
    reg_rd(`LCD_HREG_STAT, rv);
    check("err flag", {15'h0, rv[6]}, 16'h0001);
    check("line kept", {8'h00, total_line_length_o}, 16'h0007);
    // a good command clears the flag, so each refusal below is seen afresh
    reg_wr(`LCD_HREG_TCR, 8'h07);
    send_cmd(8'h04);
    reg_rd(`LCD_HREG_STAT, rv);
    check("err cleared", {15'h0, rv[6]}, 16'h0000);
    // span 4 bytes against width 13: surplus of 9 bytes is refused
    reg_wr(`LCD_HREG_APL, 8'h0d);
    send_cmd(8'h00);
    reg_rd(`LCD_HREG_STAT, rv);
    check("surplus err", {15'h0, rv[6]}, 16'h0001);
    check("width kept", virtual_width_span_o, 16'h0006);
    reg_wr(`LCD_HREG_APL, 8'h06);
    send_cmd(8'h04);
    // dual panel with an even lines parameter is refused
    reg_wr(`LCD_HREG_FMT, 8'h20);
    send_cmd(8'h00);
    reg_rd(`LCD_HREG_STAT, rv);
    check("dual err", {15'h0, rv[6]}, 16'h0001);
    check("still single", {15'h0, dual_panel_o}, 16'h0000);
    complete_run();
  end
endmodule : tb_top
